// ---- pkg/irq_ctrl_params.svh ----
// constants of the core interrupt control block: offsets, bit positions, resets
// assumes inclusion by bare name from design files
// Functional notes
// - control register holds five enables and three flags
// - control register mirrored at four bank addresses
// - top bit gates every interrupt to core
// - flags set regardless of any enable bit
// - return op loads pc, sets global enable
`ifndef IRQ_CTRL_PARAMS_SVH
`define IRQ_CTRL_PARAMS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IC_IDX_CTL_B0   10'h00B
`define IC_IDX_CTL_B1   10'h08B
`define IC_IDX_CTL_B2   10'h10B
`define IC_IDX_CTL_B3   10'h18B
`define IC_IDX_PFLAG1   10'h00C
`define IC_IDX_PFLAG2   10'h00D
`define IC_IDX_PEN1     10'h020
`define IC_IDX_PEN2     10'h021
`define IC_IDX_EVSTAT   10'h022
`define IC_IDX_EVMASK   10'h023

// ----------------------------------------------------------------
// control register bit positions
// ----------------------------------------------------------------
`define IC_BIT_GIE      7
`define IC_BIT_PERIPHERAL_GROUP_ENABLE     6
`define IC_BIT_T0IE     5
`define IC_BIT_PINIE    4
`define IC_BIT_PBIE     3
`define IC_BIT_T0IF     2
`define IC_BIT_PINIF    1
`define IC_BIT_PBIF     0

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define IC_RST_CTL      8'h00
`define IC_RST_PFLAG    8'h00
`define IC_PFLAG2_MASK  8'h01
`define IC_RESP_OKAY    2'h0
`define IC_RESP_SLVERR  2'h2

`endif

// ---- pkg/irq_ctrl_pkg.sv ----
// types shared by the interrupt control design files
// assumes nothing beyond a SystemVerilog compiler
package irq_ctrl_pkg;
    // read channel of the register slave
    typedef enum logic {
        RD_IDLE,
        RD_RESP
    } rd_state_t;
endpackage

// ---- design/axil_reg_slave.sv ----
// AXI4-Lite slave front end: turns bus transfers into register strobes
// assumes the owner decodes the index and reports a hit in the same cycle
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctrl_params.svh"
module axil_reg_slave
    import irq_ctrl_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    output logic [1:0]             s_axi_bresp_out,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    output logic [31:0]            s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    output logic                   wr_pulse_out,
    output logic [9:0]             wr_idx_out,
    output logic [7:0]             wr_data_out,
    output logic                   wr_lane_out,
    input  wire logic              wr_hit_in,
    output logic                   rd_pulse_out,
    output logic [9:0]             rd_idx_out,
    input  wire logic [7:0]        rd_data_in,
    input  wire logic              rd_hit_in
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic              aw_held_reg, aw_held_next;   // write address latched
    logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic              w_held_reg,  w_held_next;    // write data latched
    logic [7:0]        w_data_reg,  w_data_next;
    logic              w_lane_reg,  w_lane_next;    // byte lane 0 strobe
    logic              bvalid_reg,  bvalid_next;
    logic [1:0]        bresp_reg,   bresp_next;
    rd_state_t         rd_state_reg, rd_state_next;
    logic [7:0]        rdata_reg,   rdata_next;
    logic [1:0]        rresp_reg,   rresp_next;
    logic              wr_go;                       // both halves present, no response pending

    // handshake outputs straight from state
    assign s_axi_awready_out = !aw_held_reg;
    assign s_axi_wready_out  = !w_held_reg;
    assign s_axi_arready_out = (rd_state_reg == RD_IDLE);
    assign wr_go             = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_pulse_out      = wr_go;
    assign wr_idx_out        = aw_addr_reg[ADDR_W-1:2];
    assign wr_data_out       = w_data_reg;
    assign wr_lane_out       = w_lane_reg;
    assign rd_pulse_out      = s_axi_arvalid_in && s_axi_arready_out;
    assign rd_idx_out        = s_axi_araddr_in[ADDR_W-1:2];
    assign s_axi_bvalid_out  = bvalid_reg;
    assign s_axi_bresp_out   = bresp_reg;
    assign s_axi_rvalid_out  = (rd_state_reg == RD_RESP);
    assign s_axi_rresp_out   = rresp_reg;
    assign s_axi_rdata_out   = {24'h000000, rdata_reg};

    // next-state: both channels
    always_comb begin
        aw_held_next  = aw_held_reg;
        aw_addr_next  = aw_addr_reg;
        w_held_next   = w_held_reg;
        w_data_next   = w_data_reg;
        w_lane_next   = w_lane_reg;
        bvalid_next   = bvalid_reg;
        bresp_next    = bresp_reg;
        rd_state_next = rd_state_reg;
        rdata_next    = rdata_reg;
        rresp_next    = rresp_reg;
        // address and data taken in either order
        if (s_axi_awvalid_in && !aw_held_reg) begin
            aw_held_next = 1'b1;
            aw_addr_next = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !w_held_reg) begin
            w_held_next = 1'b1;
            w_data_next = s_axi_wdata_in[7:0];
            w_lane_next = s_axi_wstrb_in[0];
        end
        // commit write, raise response
        if (wr_go) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = wr_hit_in ? `IC_RESP_OKAY : `IC_RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready_in) begin
            bvalid_next = 1'b0;
        end
        // read channel
        case (rd_state_reg)
            RD_IDLE: begin
                if (s_axi_arvalid_in) begin
                    rd_state_next = RD_RESP;
                    rdata_next    = rd_hit_in ? rd_data_in : 8'h00;
                    rresp_next    = rd_hit_in ? `IC_RESP_OKAY : `IC_RESP_SLVERR;
                end
            end
            RD_RESP: begin
                if (s_axi_rready_in) begin
                    rd_state_next = RD_IDLE;
                end
            end
            default: rd_state_next = RD_IDLE;
        endcase
    end

    // registers only
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aw_held_reg  <= 1'b0;
            aw_addr_reg  <= '0;
            w_held_reg   <= 1'b0;
            w_data_reg   <= 8'h00;
            w_lane_reg   <= 1'b0;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= `IC_RESP_OKAY;
            rd_state_reg <= RD_IDLE;
            rdata_reg    <= 8'h00;
            rresp_reg    <= `IC_RESP_OKAY;
        end else begin
            aw_held_reg  <= aw_held_next;
            aw_addr_reg  <= aw_addr_next;
            w_held_reg   <= w_held_next;
            w_data_reg   <= w_data_next;
            w_lane_reg   <= w_lane_next;
            bvalid_reg   <= bvalid_next;
            bresp_reg    <= bresp_next;
            rd_state_reg <= rd_state_next;
            rdata_reg    <= rdata_next;
            rresp_reg    <= rresp_next;
        end
    end
endmodule
`default_nettype wire

// ---- design/core_interrupt_control.sv ----
// core interrupt control: enable/flag register, peripheral flags, return op
// assumes source events are one-cycle pulses synchronous to clk_in
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctrl_params.svh"
module core_interrupt_control
    import irq_ctrl_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int PC_W   = 13
) (
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    output logic [1:0]             s_axi_bresp_out,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    output logic [31:0]            s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    input  wire logic              timer0_overflow_in,  // overflow pulse
    input  wire logic              external_pin_in,     // pin edge pulse
    input  wire logic              portb_change_in,     // mismatch pulse
    input  wire logic [7:0]        periph_one_set_in,   // flag set pulses
    input  wire logic              periph_two_set_in,
    input  wire logic              irq_vector_in,       // core took vector
    input  wire logic              return_from_irq_in,  // return op executes
    input  wire logic [PC_W-1:0]   stack_top_in,        // return address
    output logic                   core_irq_out,        // request to core
    output logic                   global_enable_out,
    output logic                   pc_load_out,         // load pc pulse
    output logic [PC_W-1:0]        pc_value_out,
    output logic                   irq_out              // software line
);
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta_reg;  // first stage, read only by second
    logic rst_sync_n;    // released reset for the design

    // two-stage release of the async reset
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n   <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n   <= rst_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // bus front end
    // ----------------------------------------------------------------
    logic       wr_pulse;  // one register write
    logic [9:0] wr_idx;
    logic [7:0] wr_data;
    logic       wr_lane;   // byte 0 enabled
    logic       wr_hit;
    logic       rd_pulse;  // one register read
    logic [9:0] rd_idx;
    logic [7:0] rd_data;
    logic       rd_hit;

    axil_reg_slave #(.ADDR_W(ADDR_W)) u_slave (
        .clk_in            (clk_in),
        .rst_n_in          (rst_sync_n),
        .s_axi_awaddr_in   (s_axi_awaddr_in),
        .s_axi_awvalid_in  (s_axi_awvalid_in),
        .s_axi_awready_out (s_axi_awready_out),
        .s_axi_wdata_in    (s_axi_wdata_in),
        .s_axi_wstrb_in    (s_axi_wstrb_in),
        .s_axi_wvalid_in   (s_axi_wvalid_in),
        .s_axi_wready_out  (s_axi_wready_out),
        .s_axi_bresp_out   (s_axi_bresp_out),
        .s_axi_bvalid_out  (s_axi_bvalid_out),
        .s_axi_bready_in   (s_axi_bready_in),
        .s_axi_araddr_in   (s_axi_araddr_in),
        .s_axi_arvalid_in  (s_axi_arvalid_in),
        .s_axi_arready_out (s_axi_arready_out),
        .s_axi_rdata_out   (s_axi_rdata_out),
        .s_axi_rresp_out   (s_axi_rresp_out),
        .s_axi_rvalid_out  (s_axi_rvalid_out),
        .s_axi_rready_in   (s_axi_rready_in),
        .wr_pulse_out      (wr_pulse),
        .wr_idx_out        (wr_idx),
        .wr_data_out       (wr_data),
        .wr_lane_out       (wr_lane),
        .wr_hit_in         (wr_hit),
        .rd_pulse_out      (rd_pulse),
        .rd_idx_out        (rd_idx),
        .rd_data_in        (rd_data),
        .rd_hit_in         (rd_hit)
    );

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // one physical control register behind four bank addresses
    function automatic logic is_ctl(input logic [9:0] idx);
        is_ctl = (idx == `IC_IDX_CTL_B0) || (idx == `IC_IDX_CTL_B1) ||
                 (idx == `IC_IDX_CTL_B2) || (idx == `IC_IDX_CTL_B3);
    endfunction

    // any implemented register
    function automatic logic is_mapped(input logic [9:0] idx);
        is_mapped = is_ctl(idx) || (idx == `IC_IDX_PFLAG1) || (idx == `IC_IDX_PFLAG2) ||
                    (idx == `IC_IDX_PEN1) || (idx == `IC_IDX_PEN2) ||
                    (idx == `IC_IDX_EVSTAT) || (idx == `IC_IDX_EVMASK);
    endfunction

    logic wr_ctl;    // byte write hits control register
    logic wr_byte;   // any mapped byte write
    assign wr_hit  = is_mapped(wr_idx);
    assign rd_hit  = is_mapped(rd_idx);
    assign wr_byte = wr_pulse && wr_hit && wr_lane;
    assign wr_ctl  = wr_byte && is_ctl(wr_idx);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [7:0]      ctl_reg,    ctl_next;     // enables and core flags
    logic [7:0]      pflag1_reg, pflag1_next;  // peripheral flags one
    logic [7:0]      pflag2_reg, pflag2_next;  // peripheral flags two
    logic [7:0]      pen1_reg,   pen1_next;    // peripheral enables one
    logic [7:0]      pen2_reg,   pen2_next;    // peripheral enables two
    logic [3:0]      evstat_reg, evstat_next;  // sticky event status
    logic [3:0]      evmask_reg, evmask_next;  // event mask
    logic            creq_reg,   creq_next;    // core request
    logic            irq_reg,    irq_next;     // software interrupt line
    logic            pcld_reg,   pcld_next;    // pc load strobe
    logic [PC_W-1:0] pcval_reg,  pcval_next;   // pc load value
    logic            core_req;                 // unregistered request
    logic [3:0]      ev_in;                    // event pulses this cycle

    assign ev_in = {(|periph_one_set_in) || periph_two_set_in,
                    portb_change_in, external_pin_in, timer0_overflow_in};

    // request: global gate, then core sources or peripheral group
    assign core_req = ctl_reg[`IC_BIT_GIE] && (
        (ctl_reg[`IC_BIT_T0IE]  && ctl_reg[`IC_BIT_T0IF])  ||
        (ctl_reg[`IC_BIT_PINIE] && ctl_reg[`IC_BIT_PINIF]) ||
        (ctl_reg[`IC_BIT_PBIE]  && ctl_reg[`IC_BIT_PBIF])  ||
        (ctl_reg[`IC_BIT_PERIPHERAL_GROUP_ENABLE]  && |((pflag1_reg & pen1_reg) | (pflag2_reg & pen2_reg))));

    // next values of every register
    always_comb begin
        ctl_next    = ctl_reg;
        pflag1_next = pflag1_reg;
        pflag2_next = pflag2_reg;
        pen1_next   = pen1_reg;
        pen2_next   = pen2_reg;
        evstat_next = evstat_reg;
        evmask_next = evmask_reg;
        // software writes first
        if (wr_ctl) begin
            ctl_next = wr_data;
        end
        if (wr_byte) begin
            case (wr_idx)
                `IC_IDX_PFLAG1: pflag1_next = wr_data;
                `IC_IDX_PFLAG2: pflag2_next = wr_data & `IC_PFLAG2_MASK;
                `IC_IDX_PEN1:   pen1_next   = wr_data;
                `IC_IDX_PEN2:   pen2_next   = wr_data & `IC_PFLAG2_MASK;
                `IC_IDX_EVMASK: evmask_next = wr_data[3:0];
                default:        ;
            endcase
        end
        // reading status clears it
        if (rd_pulse && (rd_idx == `IC_IDX_EVSTAT)) begin
            evstat_next = 4'h0;
        end
        // vector entry drops global enable
        if (irq_vector_in) begin
            ctl_next[`IC_BIT_GIE] = 1'b0;
        end
        // return op sets global enable
        if (return_from_irq_in) begin
            ctl_next[`IC_BIT_GIE] = 1'b1;
        end
        // hardware sets win over clears, enables ignored
        if (timer0_overflow_in) begin
            ctl_next[`IC_BIT_T0IF] = 1'b1;
        end
        if (external_pin_in) begin
            ctl_next[`IC_BIT_PINIF] = 1'b1;
        end
        if (portb_change_in) begin
            ctl_next[`IC_BIT_PBIF] = 1'b1;
        end
        pflag1_next = pflag1_next | periph_one_set_in;
        pflag2_next[0] = pflag2_next[0] | periph_two_set_in;
        evstat_next = evstat_next | ev_in;
        // outputs
        creq_next  = core_req;
        irq_next   = |(evstat_reg & evmask_reg);
        pcld_next  = return_from_irq_in;
        pcval_next = return_from_irq_in ? stack_top_in : pcval_reg;
    end

    // registers only
    always_ff @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctl_reg    <= `IC_RST_CTL;
            pflag1_reg <= `IC_RST_PFLAG;
            pflag2_reg <= `IC_RST_PFLAG;
            pen1_reg   <= 8'h00;
            pen2_reg   <= 8'h00;
            evstat_reg <= 4'h0;
            evmask_reg <= 4'h0;
            creq_reg   <= 1'b0;
            irq_reg    <= 1'b0;
            pcld_reg   <= 1'b0;
            pcval_reg  <= '0;
        end else begin
            ctl_reg    <= ctl_next;
            pflag1_reg <= pflag1_next;
            pflag2_reg <= pflag2_next;
            pen1_reg   <= pen1_next;
            pen2_reg   <= pen2_next;
            evstat_reg <= evstat_next;
            evmask_reg <= evmask_next;
            creq_reg   <= creq_next;
            irq_reg    <= irq_next;
            pcld_reg   <= pcld_next;
            pcval_reg  <= pcval_next;
        end
    end

    // read mux, unused bits zero
    always_comb begin
        rd_data = 8'h00;
        if (is_ctl(rd_idx)) begin
            rd_data = ctl_reg;
        end else begin
            case (rd_idx)
                `IC_IDX_PFLAG1: rd_data = pflag1_reg;
                `IC_IDX_PFLAG2: rd_data = pflag2_reg;
                `IC_IDX_PEN1:   rd_data = pen1_reg;
                `IC_IDX_PEN2:   rd_data = pen2_reg;
                `IC_IDX_EVSTAT: rd_data = {4'h0, evstat_reg};
                `IC_IDX_EVMASK: rd_data = {4'h0, evmask_reg};
                default:        rd_data = 8'h00;
            endcase
        end
    end

    assign core_irq_out      = creq_reg;
    assign global_enable_out = ctl_reg[`IC_BIT_GIE];
    assign pc_load_out       = pcld_reg;
    assign pc_value_out      = pcval_reg;
    assign irq_out           = irq_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_sync_n);

    enables_write_a: assert property (wr_ctl |=> ctl_reg[6:3] == $past(wr_data[6:3]))
        else $error("control enables not written through mirror");
    // bus path: the word answered carries the shared control byte
    mirror_read_a: assert property (rd_pulse && is_ctl(rd_idx) |=>
                                    s_axi_rdata_out[7:0] == $past(ctl_reg))
        else $error("mirror read differs from control register");
    // a flag set wins over a software clear in the same cycle
    timer_flag_a: assert property (timer0_overflow_in |=> ctl_reg[`IC_BIT_T0IF])
        else $error("timer0 flag not set by overflow");
    portb_flag_a: assert property (portb_change_in && !ctl_reg[`IC_BIT_PBIE] |=> ctl_reg[`IC_BIT_PBIF])
        else $error("portb flag not set while disabled");
    pin_flag_a: assert property (external_pin_in |=> ctl_reg[`IC_BIT_PINIF])
        else $error("external pin flag not set by event");
    pin_sticky_a: assert property (ctl_reg[`IC_BIT_PINIF] && !wr_ctl |=> ctl_reg[`IC_BIT_PINIF])
        else $error("external pin flag cleared by hardware");
    return_op_a: assert property (return_from_irq_in |=> ctl_reg[`IC_BIT_GIE] && pc_load_out &&
                                  pc_value_out == $past(stack_top_in))
        else $error("return op did not load pc and set enable");
    // request lags its condition by one registered cycle
    global_block_a: assert property (!ctl_reg[`IC_BIT_GIE] ##1 !ctl_reg[`IC_BIT_GIE] |-> !core_irq_out)
        else $error("request raised with global enable clear");
    request_follow_a: assert property (ctl_reg[`IC_BIT_GIE] && ctl_reg[`IC_BIT_PERIPHERAL_GROUP_ENABLE] &&
                                       (pflag1_reg[0] && pen1_reg[0]) |=> core_irq_out)
        else $error("peripheral request not forwarded");
    status_line_a: assert property (|(evstat_reg & evmask_reg) |=> irq_out)
        else $error("interrupt line low with unmasked status");

    // main scenarios
    ret_cov: cover property (return_from_irq_in ##1 pc_load_out);
    req_cov: cover property (!core_irq_out ##1 core_irq_out);
    stat_clear_cov: cover property (irq_out ##1 rd_pulse && rd_idx == `IC_IDX_EVSTAT);
    pin_cov: cover property (external_pin_in ##1 ctl_reg[`IC_BIT_PINIF]);
    vec_cov: cover property (irq_vector_in ##1 !global_enable_out);
endmodule
`default_nettype wire

// ---- testbench/core_fetch_model.sv ----
// partner core: takes interrupt vectors and runs the return op
// assumes the bench asks for a vector take or a return by level
`timescale 1ns/100ps
`default_nettype none
module core_fetch_model (
    input  wire logic   clk_in,
    input  wire logic   take_in,
    input  wire logic   core_irq_in,
    input  wire logic   ret_req_in,
    output logic        vector_out = 1'b0,
    output logic        return_out = 1'b0,
    output logic [12:0] stack_top_out = 13'h0000
);
    // vector pulses on alternate cycles while take and request stay high; stack top valid only with the return
    always @(posedge clk_in) begin
        vector_out    <= take_in & core_irq_in & ~vector_out;
        return_out    <= ret_req_in;
        stack_top_out <= ret_req_in ? 13'h1ABC : ~stack_top_out;
    end
endmodule
`default_nettype wire

// ---- testbench/core_interrupt_control_tb.sv ----
// self-checking bench of the core interrupt control block
// assumes the partner core model and an AXI4-Lite master task pair
`timescale 1ns/100ps
`default_nettype none
module core_interrupt_control_tb;
    logic clk = 0, rst_n = 0, awv = 0, wv = 0, arv = 0, take = 0, rreq = 0;
    logic [11:0] aw = 0, ar = 0;
    logic [31:0] wd = 0, rdat;
    logic [2:0] ev = 0;
    logic [7:0] p1 = 0;
    logic awr, wr_, bv, arr, rv, cirq, gen, pcl, irq, vec, ret;
    logic [1:0] br, rr;
    logic [12:0] st, pcv;
    int miscompares = 0, n_tests = 0;
    core_interrupt_control dut_u (.clk_in(clk), .rst_n_in(rst_n), .s_axi_awaddr_in(aw), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wr_), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(1'b1),
        .s_axi_araddr_in(ar), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
        .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(1'b1), .timer0_overflow_in(ev[0]),
        .external_pin_in(ev[1]), .portb_change_in(ev[2]), .periph_one_set_in(p1), .periph_two_set_in(ev[2]),
        .irq_vector_in(vec), .return_from_irq_in(ret), .stack_top_in(st), .core_irq_out(cirq),
        .global_enable_out(gen), .pc_load_out(pcl), .pc_value_out(pcv), .irq_out(irq));
    core_fetch_model core_u (.clk_in(clk), .take_in(take), .core_irq_in(cirq), .ret_req_in(rreq),
        .vector_out(vec), .return_out(ret), .stack_top_out(st));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic chk_now(input logic s, input logic e);
        @(negedge clk);
        chk(32'(s), 32'(e));
        @(posedge clk);
    endtask
    // bus write: hold each channel until taken, wait for the response
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        logic ta, tw, g;
        logic [1:0] rp;
        aw <= a;
        wd <= {24'h000000, d};
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(negedge clk);
            {ta, tw, g, rp} = {awv & awr, wv & wr_, bv, br};
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while (!g);
        chk(32'(rp), 32'(r));
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r);
        logic ta, g;
        logic [33:0] v;
        ar <= a;
        arv <= 1'b1;
        do begin
            @(negedge clk);
            {ta, g, v} = {arv & arr, rv, rr, rdat};
            @(posedge clk);
            if (ta) arv <= 1'b0;
        end while (!g);
        chk(v[31:0], {24'h000000, e});
        chk(32'(v[33:32]), 32'(r));
    endtask
    task automatic pulse(input logic [2:0] e, input logic [7:0] p);
        ev <= e;
        p1 <= p;
        @(posedge clk);
        ev <= 3'h0;
        p1 <= 8'h00;
        repeat (2) @(posedge clk);
    endtask
    task automatic t_regs();
        rd(12'h02C, 8'h00, 2'h0);
        wr(12'h22C, 8'h38, 2'h0);
        for (int i = 0; i < 4; i++) rd(12'h02C + 12'(i * 512), 8'h38, 2'h0);
        wr(12'h3FC, 8'hFF, 2'h2);
        rd(12'h3FC, 8'h00, 2'h2);
        wr(12'h034, 8'hFF, 2'h0);
        rd(12'h034, 8'h01, 2'h0);
        wr(12'h034, 8'h00, 2'h0);
    endtask
    task automatic t_flags();
        pulse(3'h7, 8'h00);
        rd(12'h02C, 8'h3F, 2'h0);
        rd(12'h034, 8'h01, 2'h0);
        chk_now(cirq, 1'b0);
        wr(12'h02C, 8'hBF, 2'h0);
        repeat (2) @(posedge clk);
        chk_now(cirq, 1'b1);
        repeat (20) @(posedge clk);
        rd(12'h02C, 8'hBF, 2'h0);
        wr(12'h02C, 8'h80, 2'h0);
        wr(12'h02C, 8'h90, 2'h0);
        chk_now(cirq, 1'b0);
    endtask
    task automatic t_periph();
        wr(12'h080, 8'h01, 2'h0);
        pulse(3'h0, 8'h01);
        rd(12'h030, 8'h01, 2'h0);
        chk_now(cirq, 1'b0);
        wr(12'h02C, 8'hC0, 2'h0);
        repeat (2) @(posedge clk);
        chk_now(cirq, 1'b1);
        wr(12'h08C, 8'h00, 2'h0);
        chk_now(irq, 1'b0);
        wr(12'h08C, 8'h0F, 2'h0);
        repeat (2) @(posedge clk);
        chk_now(irq, 1'b1);
        rd(12'h088, 8'h0F, 2'h0);
        repeat (2) @(posedge clk);
        chk_now(irq, 1'b0);
    endtask
    // vector clears the enable, the return op restores it with the stack top
    task automatic t_return();
        logic g;
        g = 1'b0;
        take <= 1'b1;
        repeat (3) @(posedge clk);
        take <= 1'b0;
        chk_now(gen, 1'b0);
        rreq <= 1'b1;
        @(posedge clk);
        rreq <= 1'b0;
        for (int i = 0; i < 6 && !g; i++) begin
            @(negedge clk);
            g = (pcl === 1'b1);
            if (g) chk({18'h0, pcv, gen}, {18'h0, 13'h1ABC, 1'b1});
        end
        chk(32'(g), 32'h1);
        @(posedge clk);
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_flags();
        t_periph();
        t_return();
        print_verdict();
    end
endmodule
`default_nettype wire
